// file: tmr16_top.sv
// Purpose: 16-bit timer registers, flags, requests and pin multiplexer
// Assumes: i_timer_tick is the prescaled one-cycle timer enable
// Notes: read data appears one cycle after the read strobe
`timescale 1ns/1ns
module tmr16_top (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic [7:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [7:0] i_io_wdata,
  output logic [7:0] o_io_rdata,
  input wire logic i_timer_tick,
  input wire logic i_capture_input_pin,
  input wire logic i_comparator_out,
  input wire logic i_global_irq_enable,
  input wire logic i_capture_vector_ack,
  input wire logic i_compare_a_vector_ack,
  input wire logic i_compare_b_vector_ack,
  input wire logic i_overflow_vector_ack,
  input wire logic [1:0] i_timer0_compare_output,
  input wire logic [1:0] i_timer2_compare_output,
  output logic o_capture_irq,
  output logic o_compare_a_irq,
  output logic o_compare_b_irq,
  output logic o_overflow_irq,
  output logic o_channel_a_compare_output,
  output logic o_channel_b_compare_output,
  output logic [7:0] o_timer_output_pin,
  output logic [7:0] o_timer_output_pin_oe
);
  import tmr16_pkg::*;

  logic [15:0] counter_value_reg;
  logic [15:0] counter_value_next;
  logic [15:0] compare_value_a_reg;
  logic [15:0] compare_value_b_reg;
  logic [15:0] capture_value_reg;
  logic [7:0] high_latch_reg;
  logic [7:0] pin_channel_select_low_reg;
  logic [7:0] pin_channel_select_high_reg;
  logic [7:0] pin_channel_output_enables_reg;
  logic [7:0] interrupt_mask_reg;
  logic [7:0] interrupt_flags_reg;
  logic [7:0] interrupt_flags_next;
  logic [7:0] ctrl_reg;
  logic count_up_reg;
  logic count_up_next;
  logic match_block_reg;
  logic capt_prev_reg;
  logic oc_a_reg;
  logic oc_b_reg;
  logic [7:0] rdata_reg;

  // address decode
  wire wr_cnt_l = i_io_wr && i_io_addr == ADDR_CNT_L;
  wire wr_cmpa_l = i_io_wr && i_io_addr == ADDR_CMPA_L;
  wire wr_cmpb_l = i_io_wr && i_io_addr == ADDR_CMPB_L;
  wire wr_capt_l = i_io_wr && i_io_addr == ADDR_CAPT_L;
  wire wr_high = i_io_wr && (i_io_addr == ADDR_CNT_H ||
                 i_io_addr == ADDR_CMPA_H || i_io_addr == ADDR_CMPB_H ||
                 i_io_addr == ADDR_CAPT_H);
  wire rd_cnt_l = i_io_rd && i_io_addr == ADDR_CNT_L;
  wire rd_cmpa_l = i_io_rd && i_io_addr == ADDR_CMPA_L;
  wire rd_cmpb_l = i_io_rd && i_io_addr == ADDR_CMPB_L;
  wire rd_capt_l = i_io_rd && i_io_addr == ADDR_CAPT_L;
  wire wr_sel_low = i_io_wr && i_io_addr == ADDR_SEL_LOW;
  wire wr_sel_high = i_io_wr && i_io_addr == ADDR_SEL_HIGH;
  wire wr_oe = i_io_wr && i_io_addr == ADDR_OE;
  wire wr_mask = i_io_wr && i_io_addr == ADDR_MASK;
  wire wr_flags = i_io_wr && i_io_addr == ADDR_FLAGS;
  wire wr_ctrl = i_io_wr && i_io_addr == ADDR_CTRL;
  wire wr_force = i_io_wr && i_io_addr == ADDR_FORCE;

  // low byte write commits both bytes through the latch
  wire [15:0] wr_word = {high_latch_reg, i_io_wdata};

  // mode decode
  wire [3:0] waveform_mode_select = ctrl_reg[CTRL_MODE_LSB +: 4];
  wire tmr16_top_src_t top_src = tmr16_top_src(waveform_mode_select);
  wire tmr16_ovf_at_t ovf_at = tmr16_ovf_at(waveform_mode_select);
  wire capt_is_top = top_src == TMR16_TOP_CAPT;
  wire up_down = ovf_at == TMR16_OVF_AT_BOTTOM;
  wire non_pwm = ovf_at == TMR16_OVF_AT_MAX;
  wire [15:0] fixed_top = (waveform_mode_select[1:0] == 2'h1) ? TOP_8BIT :
                          (waveform_mode_select[1:0] == 2'h2) ? TOP_9BIT :
                          (waveform_mode_select[1:0] == 2'h3) ? TOP_10BIT :
                          VAL_MAX;
  wire [15:0] top_val = (top_src == TMR16_TOP_CMPA) ? compare_value_a_reg :
                        capt_is_top ? capture_value_reg : fixed_top;
  wire at_top = counter_value_reg == top_val;
  wire at_bottom = counter_value_reg == VAL_BOTTOM;

  // compare units, suppressed on the tick after a counter write
  wire eq_a = counter_value_reg == compare_value_a_reg;
  wire eq_b = counter_value_reg == compare_value_b_reg;
  wire hit_a = i_timer_tick && !match_block_reg && eq_a;
  wire hit_b = i_timer_tick && !match_block_reg && eq_b;

  // forced compare only acts in non-pwm modes
  wire force_a = wr_force && i_io_wdata[FORCE_A_BIT] && non_pwm;
  wire force_b = wr_force && i_io_wdata[FORCE_B_BIT] && non_pwm;

  // overflow point depends on mode
  wire ovf_evt = i_timer_tick && (
    (ovf_at == TMR16_OVF_AT_MAX && counter_value_reg == VAL_MAX) ||
    (ovf_at == TMR16_OVF_AT_TOP && at_top) ||
    (ovf_at == TMR16_OVF_AT_BOTTOM && at_bottom &&
     !count_up_reg));

  // capture front end; the pin is off while capture is top
  wire capt_src = ctrl_reg[CTRL_ACMP_BIT] ? i_comparator_out
                                          : i_capture_input_pin;
  wire capt_rise = capt_src && !capt_prev_reg;
  wire capt_fall = !capt_src && capt_prev_reg;
  wire capt_edge = ctrl_reg[CTRL_EDGE_BIT] ? capt_rise : capt_fall;
  wire capt_evt = capt_edge && !capt_is_top;
  wire capt_flag_evt = capt_is_top ? (i_timer_tick && at_top)
                                   : capt_evt;

  // counter step
  always_comb begin
    counter_value_next = counter_value_reg;
    count_up_next = count_up_reg;
    if (i_timer_tick) begin
      if (up_down) begin
        if (count_up_reg && at_top) begin
          count_up_next = 1'b0;
          counter_value_next = counter_value_reg - 16'h0001;
        end else if (!count_up_reg && at_bottom) begin
          count_up_next = 1'b1;
          counter_value_next = counter_value_reg + 16'h0001;
        end else if (count_up_reg) begin
          counter_value_next = counter_value_reg + 16'h0001;
        end else begin
          counter_value_next = counter_value_reg - 16'h0001;
        end
      end else if (at_top) begin
        count_up_next = 1'b1;
        counter_value_next = VAL_BOTTOM;
      end else begin
        count_up_next = 1'b1;
        counter_value_next = counter_value_reg + 16'h0001;
      end
    end
    // a cpu write overrides the step in the same cycle
    if (wr_cnt_l) begin
      counter_value_next = wr_word;
    end
  end

  // flags: hardware set wins over vector or one-write clear
  wire [7:0] flag_set = {2'b00, capt_flag_evt, 2'b00, hit_b, hit_a,
                         ovf_evt};
  wire [7:0] flag_ack = {2'b00, i_capture_vector_ack, 2'b00,
                         i_compare_b_vector_ack, i_compare_a_vector_ack,
                         i_overflow_vector_ack};
  wire [7:0] flag_w1c = wr_flags ? i_io_wdata : RST_BYTE;
  assign interrupt_flags_next =
    ((interrupt_flags_reg & ~(flag_ack | flag_w1c)) | flag_set)
    & IRQ_USED;

  // requests need flag, mask and global enable together
  wire [7:0] irq_req = interrupt_flags_reg & interrupt_mask_reg &
                       {8{i_global_irq_enable}};

  // read data; a high byte read returns the shared latch
  wire [7:0] rd_val =
    (i_io_addr == ADDR_CNT_L) ? counter_value_reg[7:0] :
    (i_io_addr == ADDR_CMPA_L) ? compare_value_a_reg[7:0] :
    (i_io_addr == ADDR_CMPB_L) ? compare_value_b_reg[7:0] :
    (i_io_addr == ADDR_CAPT_L) ? capture_value_reg[7:0] :
    (i_io_addr == ADDR_CNT_H || i_io_addr == ADDR_CMPA_H ||
     i_io_addr == ADDR_CMPB_H || i_io_addr == ADDR_CAPT_H) ?
      high_latch_reg :
    (i_io_addr == ADDR_SEL_LOW) ? pin_channel_select_low_reg :
    (i_io_addr == ADDR_SEL_HIGH) ? pin_channel_select_high_reg :
    (i_io_addr == ADDR_OE) ? pin_channel_output_enables_reg :
    (i_io_addr == ADDR_MASK) ? interrupt_mask_reg :
    (i_io_addr == ADDR_FLAGS) ? interrupt_flags_reg :
    (i_io_addr == ADDR_CTRL) ? ctrl_reg :
    RST_BYTE;

  // latch source: high half of the word whose low byte is read
  wire [7:0] rd_high =
    rd_cnt_l ? counter_value_reg[15:8] :
    rd_cmpa_l ? compare_value_a_reg[15:8] :
    rd_cmpb_l ? compare_value_b_reg[15:8] :
    capture_value_reg[15:8];
  wire rd_low_any = rd_cnt_l || rd_cmpa_l || rd_cmpb_l || rd_capt_l;

  // shared high byte latch
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      high_latch_reg <= RST_BYTE;
    end else if (wr_high) begin
      high_latch_reg <= i_io_wdata;
    end else if (rd_low_any) begin
      high_latch_reg <= rd_high;
    end
  end

  // counter and direction
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      counter_value_reg <= RST_WORD;
      count_up_reg <= 1'b1;
    end else begin
      counter_value_reg <= counter_value_next;
      count_up_reg <= count_up_next;
    end
  end

  // write block holds until the next timer tick consumes it
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      match_block_reg <= 1'b0;
    end else if (wr_cnt_l) begin
      match_block_reg <= 1'b1;
    end else if (i_timer_tick) begin
      match_block_reg <= 1'b0;
    end
  end

  // compare values
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      compare_value_a_reg <= RST_WORD;
      compare_value_b_reg <= RST_WORD;
    end else begin
      if (wr_cmpa_l) begin
        compare_value_a_reg <= wr_word;
      end
      if (wr_cmpb_l) begin
        compare_value_b_reg <= wr_word;
      end
    end
  end

  // capture value; hardware capture wins over a cpu write
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      capture_value_reg <= RST_WORD;
      capt_prev_reg <= 1'b0;
    end else begin
      capt_prev_reg <= capt_src;
      if (capt_evt) begin
        capture_value_reg <= counter_value_reg;
      end else if (wr_capt_l) begin
        capture_value_reg <= wr_word;
      end
    end
  end

  // byte registers
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      pin_channel_select_low_reg <= RST_BYTE;
      pin_channel_select_high_reg <= RST_BYTE;
      pin_channel_output_enables_reg <= RST_BYTE;
      interrupt_mask_reg <= RST_BYTE;
      ctrl_reg <= RST_BYTE;
    end else begin
      if (wr_sel_low) pin_channel_select_low_reg <= i_io_wdata;
      if (wr_sel_high) pin_channel_select_high_reg <= i_io_wdata;
      if (wr_oe) pin_channel_output_enables_reg <= i_io_wdata;
      // reserved mask bits are not stored and read zero
      if (wr_mask) interrupt_mask_reg <= i_io_wdata & IRQ_USED;
      if (wr_ctrl) ctrl_reg <= {2'b00, i_io_wdata[5:0]};
    end
  end

  // flags and request outputs
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      interrupt_flags_reg <= RST_BYTE;
      o_capture_irq <= 1'b0;
      o_compare_a_irq <= 1'b0;
      o_compare_b_irq <= 1'b0;
      o_overflow_irq <= 1'b0;
    end else begin
      interrupt_flags_reg <= interrupt_flags_next;
      o_capture_irq <= irq_req[BIT_CAPT];
      o_compare_a_irq <= irq_req[BIT_CMPA];
      o_compare_b_irq <= irq_req[BIT_CMPB];
      o_overflow_irq <= irq_req[BIT_OVF];
    end
  end

  // own compare outputs toggle on match or forced strobe
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      oc_a_reg <= 1'b0;
      oc_b_reg <= 1'b0;
    end else begin
      if (hit_a || force_a) oc_a_reg <= !oc_a_reg;
      if (hit_b || force_b) oc_b_reg <= !oc_b_reg;
    end
  end

  // read data register, held until the next read strobe
  // so a slow poll still sees the answer it asked for
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      rdata_reg <= RST_BYTE;
    end else if (i_io_rd) begin
      rdata_reg <= rd_val;
    end
  end

  // pin multiplexer, this timer sits in slot 1
  logic [7:0] mux_pin;
  logic [7:0] mux_oe;

  tmr16_pinmux u_pinmux (
    .i_pin_channel_select({pin_channel_select_high_reg,
                           pin_channel_select_low_reg}),
    .i_pin_channel_output_enables(pin_channel_output_enables_reg),
    .i_channel_a_compare_output({i_timer2_compare_output[1], oc_a_reg,
                                 i_timer0_compare_output[1]}),
    .i_channel_b_compare_output({i_timer2_compare_output[0], oc_b_reg,
                                 i_timer0_compare_output[0]}),
    .o_timer_output_pin(mux_pin),
    .o_timer_output_pin_oe(mux_oe)
  );

  // registered pins; one cycle of lag buys glitch-free outputs
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_timer_output_pin <= RST_BYTE;
      o_timer_output_pin_oe <= RST_BYTE;
    end else begin
      o_timer_output_pin <= mux_pin;
      o_timer_output_pin_oe <= mux_oe;
    end
  end

  assign o_io_rdata = rdata_reg;
  assign o_channel_a_compare_output = oc_a_reg;
  assign o_channel_b_compare_output = oc_b_reg;
endmodule : tmr16_top

// file: tmr16_pkg.sv
// Purpose: constants, types and decode functions of the 16-bit timer block
// Assumes: 8-bit cpu i/o bus, one 20 MHz clock, timer ticks come as enables
// Notes: every register resets to zero, counter counts up
// Function
// - two select bits choose timer per pin
// - even pins channel b, odd pins a
// - enable drives pin whatever compare mode
// - cpu reads and writes whole counter
// - one shared high byte latch
// - counter write blocks next tick's matches
// - compares run continuously, raise flag, output
// - capture copies counter from pin/comparator
// - capture value may serve as top
// - request needs flag, mask, global enable
// - capture flag on event or top
// - compare flag set tick after equality
// - force strobe changes output in non-pwm modes, no flag
// - flags clear on vector or one-write
// - overflow flag point follows waveform mode
package tmr16_pkg;
  // register offsets on the i/o bus
  localparam logic [7:0] ADDR_CNT_L = 8'h60;
  localparam logic [7:0] ADDR_CNT_H = 8'h61;
  localparam logic [7:0] ADDR_CMPA_L = 8'h62;
  localparam logic [7:0] ADDR_CMPA_H = 8'h63;
  localparam logic [7:0] ADDR_CMPB_L = 8'h64;
  localparam logic [7:0] ADDR_CMPB_H = 8'h65;
  localparam logic [7:0] ADDR_SEL_LOW = 8'h67;
  localparam logic [7:0] ADDR_SEL_HIGH = 8'h68;
  localparam logic [7:0] ADDR_CAPT_L = 8'h69;
  localparam logic [7:0] ADDR_CAPT_H = 8'h6a;
  localparam logic [7:0] ADDR_MASK = 8'h6b;
  localparam logic [7:0] ADDR_FLAGS = 8'h6c;
  localparam logic [7:0] ADDR_OE = 8'h6d;
  localparam logic [7:0] ADDR_CTRL = 8'h6e;
  localparam logic [7:0] ADDR_FORCE = 8'h6f;
  // interrupt bit positions, shared by mask and flags
  localparam int BIT_CAPT = 5;
  localparam int BIT_CMPB = 2;
  localparam int BIT_CMPA = 1;
  localparam int BIT_OVF = 0;
  localparam logic [7:0] IRQ_USED = 8'h27;
  // control and force register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_EDGE_BIT = 4;
  localparam int CTRL_ACMP_BIT = 5;
  localparam int FORCE_A_BIT = 7;
  localparam int FORCE_B_BIT = 6;
  // reset values and fixed tops
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] VAL_MAX = 16'hffff;
  localparam logic [15:0] VAL_BOTTOM = 16'h0000;
  localparam logic [15:0] TOP_8BIT = 16'h00ff;
  localparam logic [15:0] TOP_9BIT = 16'h01ff;
  localparam logic [15:0] TOP_10BIT = 16'h03ff;

  typedef enum logic [1:0] {
    TMR16_TOP_FIXED,
    TMR16_TOP_CMPA,
    TMR16_TOP_CAPT
  } tmr16_top_src_t;

  typedef enum logic [1:0] {
    TMR16_OVF_AT_MAX,
    TMR16_OVF_AT_TOP,
    TMR16_OVF_AT_BOTTOM
  } tmr16_ovf_at_t;

  function automatic tmr16_top_src_t tmr16_top_src(input logic [3:0] m);
    case (m)
      4'h4, 4'h9, 4'hb, 4'hf: tmr16_top_src = TMR16_TOP_CMPA;
      4'h8, 4'ha, 4'hc, 4'he: tmr16_top_src = TMR16_TOP_CAPT;
      default: tmr16_top_src = TMR16_TOP_FIXED;
    endcase
  endfunction : tmr16_top_src

  function automatic tmr16_ovf_at_t tmr16_ovf_at(input logic [3:0] m);
    case (m)
      4'h0, 4'h4, 4'hc: tmr16_ovf_at = TMR16_OVF_AT_MAX;
      4'h5, 4'h6, 4'h7, 4'he, 4'hf: tmr16_ovf_at = TMR16_OVF_AT_TOP;
      default: tmr16_ovf_at = TMR16_OVF_AT_BOTTOM;
    endcase
  endfunction : tmr16_ovf_at
endpackage : tmr16_pkg

// file: tmr16_pinmux.sv
// Purpose: route six compare outputs of three timers onto eight pins
// Assumes: compare outputs are levels in the same clock domain
// Notes: purely combinational, the top registers the result
`timescale 1ns/1ns
module tmr16_pinmux (
  input wire logic [15:0] i_pin_channel_select,
  input wire logic [7:0] i_pin_channel_output_enables,
  input wire logic [2:0] i_channel_a_compare_output,
  input wire logic [2:0] i_channel_b_compare_output,
  output logic [7:0] o_timer_output_pin,
  output logic [7:0] o_timer_output_pin_oe
);
  import tmr16_pkg::*;

  always_comb begin
    for (int p = 0; p < 8; p++) begin
      logic [1:0] sel;
      logic [2:0] src;
      sel = i_pin_channel_select[2*p +: 2];
      // even pins take channel b, odd pins channel a
      src = p[0] ? i_channel_a_compare_output
                 : i_channel_b_compare_output;
      // code 1x picks timer 2 whatever the low bit says
      o_timer_output_pin[p] = sel[1] ? src[2]
                            : (sel[0] ? src[1] : src[0]);
    end
  end

  // enable alone decides the drive, no compare mode check
  assign o_timer_output_pin_oe = i_pin_channel_output_enables;
endmodule : tmr16_pinmux

// file: tmr16_sva.sv
// Purpose: port checks for the 16-bit timer block
// Assumes: bound into tmr16_top, one clock domain
// Notes: select registers shadowed from bus writes
`timescale 1ns/1ns
module tmr16_sva (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic [7:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [7:0] i_io_wdata,
  input wire logic [7:0] o_io_rdata,
  input wire logic i_global_irq_enable,
  input wire logic [1:0] i_timer0_compare_output,
  input wire logic [1:0] i_timer2_compare_output,
  input wire logic o_capture_irq,
  input wire logic o_compare_a_irq,
  input wire logic o_compare_b_irq,
  input wire logic o_overflow_irq,
  input wire logic o_channel_a_compare_output,
  input wire logic o_channel_b_compare_output,
  input wire logic [7:0] o_timer_output_pin,
  input wire logic [7:0] o_timer_output_pin_oe
);
  import tmr16_pkg::*;
  logic [15:0] sel_sh;
  logic [7:0] exp_pin;
  wire [1:0] t1_oc = {o_channel_a_compare_output, o_channel_b_compare_output};
  wire wr_sel_lo = i_io_wr && i_io_addr == ADDR_SEL_LOW;
  wire wr_sel_hi = i_io_wr && i_io_addr == ADDR_SEL_HIGH;
  wire wr_mask = i_io_wr && i_io_addr == ADDR_MASK;
  wire any_irq = o_capture_irq || o_compare_a_irq || o_compare_b_irq ||
    o_overflow_irq;
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      sel_sh <= 16'h0000;
    end else if (wr_sel_lo) begin
      sel_sh[7:0] <= i_io_wdata;
    end else if (wr_sel_hi) begin
      sel_sh[15:8] <= i_io_wdata;
    end
  end
  // pin flop sees last cycle's select and sources
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      exp_pin[i] = sel_sh[2*i+1] ? i_timer2_compare_output[i%2] :
        sel_sh[2*i] ? t1_oc[i%2] : i_timer0_compare_output[i%2];
    end
  end
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_srst);
  sequence s_mask_off;
    wr_mask && i_io_wdata == 8'h00 ##1 !wr_mask;
  endsequence
  a_pin_route: assert property (!$past(i_srst) |->
    ((o_timer_output_pin ^ $past(exp_pin)) & o_timer_output_pin_oe) == 8'h00)
    else $error("pin value differs from selected channel");
  a_oe_follow: assert property (i_io_wr && i_io_addr == ADDR_OE |->
    ##2 o_timer_output_pin_oe == $past(i_io_wdata, 2))
    else $error("pin enables do not follow register write");
  a_rdata_hold: assert property (!i_io_rd |=> $stable(o_io_rdata))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (
    i_io_rd && i_io_addr == 8'h66 |=> o_io_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_mask_off: assert property (s_mask_off |=> !any_irq)
    else $error("request with all masks clear");
  a_capt_gie: assert property (o_capture_irq |->
    $past(i_global_irq_enable))
    else $error("capture request without global enable");
  a_cmpa_gie: assert property (!i_global_irq_enable |=>
    !o_compare_a_irq)
    else $error("compare a request without global enable");
  a_cmpb_gie: assert property ($rose(o_compare_b_irq) |->
    $past(i_global_irq_enable)) else $error("compare b request ungated");
  a_ovf_gie: assert property (!$past(i_global_irq_enable) |->
    !o_overflow_irq) else $error("overflow request ungated");
  c_irq_a: cover property (o_compare_a_irq);
  c_irq_c: cover property (o_capture_irq);
  c_oe_wr: cover property (i_io_wr && i_io_addr == ADDR_OE);
endmodule : tmr16_sva

// file: tmr16_pin_env.sv
// Purpose: board side of the eight timer output pins
// Assumes: every pad has a pull-up
// Notes: an undriven pad shows the pull-up, never the stale value
`timescale 1ns/1ns
module tmr16_pin_env (
  input wire logic [7:0] i_pin,
  input wire logic [7:0] i_pin_oe,
  output logic [7:0] o_pad
);
  assign o_pad = (i_pin & i_pin_oe) | ~i_pin_oe;
endmodule : tmr16_pin_env

// file: tb_top.sv
// Purpose: self-checking bench for the 16-bit timer block
// Assumes: read data answers one cycle after the strobe
// Notes: read results pass through a queue to a monitor
`timescale 1ns/1ns
module tb_top;
  import tmr16_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic tick = 1'b0;
  logic cap_pin = 1'b0;
  logic cmp_out = 1'b0;
  logic gie = 1'b0;
  logic [3:0] ack = 4'h0;
  logic [1:0] t0 = 2'b00;
  logic [1:0] t2 = 2'b00;
  logic [7:0] rdata, pin, pin_oe, pad;
  logic irq_c, irq_a, irq_b, irq_o, oc_a, oc_b;
  logic rd_pend = 1'b0;
  logic [7:0] expq[$];
  logic [7:0] rst_a[9] = '{ADDR_SEL_LOW, ADDR_SEL_HIGH, ADDR_OE, ADDR_MASK,
    ADDR_FLAGS, ADDR_FORCE, 8'h66, ADDR_CNT_L, ADDR_CNT_H};
  int mismatches = 0;
  int cmp_count = 0;
  tmr16_top dut (
    .i_ref_clk(clk), .i_srst(srst), .i_io_addr(addr), .i_io_wr(wr),
    .i_io_rd(rd), .i_io_wdata(wdata), .o_io_rdata(rdata),
    .i_timer_tick(tick), .i_capture_input_pin(cap_pin),
    .i_comparator_out(cmp_out), .i_global_irq_enable(gie),
    .i_capture_vector_ack(ack[3]), .i_compare_a_vector_ack(ack[1]),
    .i_compare_b_vector_ack(ack[2]), .i_overflow_vector_ack(ack[0]),
    .i_timer0_compare_output(t0), .i_timer2_compare_output(t2),
    .o_capture_irq(irq_c), .o_compare_a_irq(irq_a),
    .o_compare_b_irq(irq_b), .o_overflow_irq(irq_o),
    .o_channel_a_compare_output(oc_a), .o_channel_b_compare_output(oc_b),
    .o_timer_output_pin(pin), .o_timer_output_pin_oe(pin_oe));
  tmr16_pin_env env (.i_pin(pin), .i_pin_oe(pin_oe), .o_pad(pad));
  always #25 clk = ~clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // read data is taken the edge after the design took the strobe
  always @(posedge clk) begin
    if (rd_pend && expq.size() > 0) begin
      chk(rdata, expq.pop_front());
    end
    rd_pend <= rd;
  end
  // for a read, d is the expected answer
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    if (!w) expq.push_back(d);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : acc
  task automatic w16(input logic [7:0] a, input logic [15:0] v);
    acc(1'b1, a + 8'h01, v[15:8]);
    acc(1'b1, a, v[7:0]);
  endtask : w16
  task automatic r16(input logic [7:0] a, input logic [15:0] v);
    acc(1'b0, a, v[7:0]);
    acc(1'b0, a + 8'h01, v[15:8]);
  endtask : r16
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
    end
  endtask : ticks
  task automatic pulse(input logic [3:0] v);
    @(posedge clk);
    ack <= v;
    @(posedge clk);
    ack <= 4'h0;
  endtask : pulse
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim
  initial begin
    #2000000;
    mismatches++;
    end_sim();
  end
  initial begin
    logic [15:0] v, s;
    logic [7:0] oe;
    logic [1:0] ocs;
    logic e;
    void'($urandom(59));
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    acc(1'b1, 8'h66, 8'h5a);
    foreach (rst_a[i]) acc(1'b0, rst_a[i], 8'h00);
    acc(1'b1, ADDR_MASK, 8'h27);
    acc(1'b0, ADDR_MASK, 8'h27);
    $display("test reset done");
    v = 16'($urandom());
    w16(ADDR_CNT_L, v);
    r16(ADDR_CNT_L, v);
    acc(1'b1, ADDR_CMPA_H, v[7:0]);
    acc(1'b1, ADDR_CMPA_L, v[15:8]);
    acc(1'b1, ADDR_CMPB_L, 8'h77);
    r16(ADDR_CMPA_L, {v[7:0], v[15:8]});
    r16(ADDR_CMPB_L, {v[7:0], 8'h77});
    w16(ADDR_CAPT_L, ~v);
    r16(ADDR_CAPT_L, ~v);
    acc(1'b0, ADDR_CNT_L, v[7:0]);
    acc(1'b0, ADDR_CAPT_H, v[15:8]);
    $display("test wide access done");
    w16(ADDR_CMPA_L, 16'h0005);
    w16(ADDR_CMPB_L, 16'h0007);
    w16(ADDR_CNT_L, 16'h0003);
    acc(1'b1, ADDR_MASK, 8'h06);
    gie <= 1'b1;
    ticks(2);
    acc(1'b0, ADDR_FLAGS, 8'h00);
    ticks(1);
    acc(1'b0, ADDR_FLAGS, 8'h02);
    chk(irq_a, 1'b1);
    chk(irq_b, 1'b0);
    chk(oc_a, 1'b1);
    ticks(2);
    acc(1'b0, ADDR_FLAGS, 8'h06);
    chk(oc_b, 1'b1);
    acc(1'b1, ADDR_FLAGS, 8'h02);
    acc(1'b0, ADDR_FLAGS, 8'h04);
    acc(1'b1, ADDR_FLAGS, 8'h00);
    acc(1'b0, ADDR_FLAGS, 8'h04);
    chk(irq_b, 1'b1);
    acc(1'b1, ADDR_MASK, 8'h00);
    pulse(4'h4);
    acc(1'b0, ADDR_FLAGS, 8'h00);
    $display("test compare done");
    w16(ADDR_CNT_L, 16'h0005);
    ticks(2);
    acc(1'b0, ADDR_FLAGS, 8'h00);
    chk(oc_a, 1'b1);
    acc(1'b1, ADDR_FORCE, 8'hc0);
    repeat (3) @(posedge clk);
    chk({oc_a, oc_b}, 2'b00);
    acc(1'b0, ADDR_FLAGS, 8'h00);
    acc(1'b1, ADDR_MASK, 8'h01);
    w16(ADDR_CNT_L, 16'hffff);
    ticks(1);
    acc(1'b0, ADDR_FLAGS, 8'h01);
    chk(irq_o, 1'b1);
    r16(ADDR_CNT_L, 16'h0000);
    pulse(4'h1);
    acc(1'b0, ADDR_FLAGS, 8'h00);
    acc(1'b1, ADDR_CTRL, 8'h01);
    w16(ADDR_CNT_L, 16'h00ff);
    ticks(1);
    w16(ADDR_CNT_L, 16'h0001);
    ticks(2);
    acc(1'b0, ADDR_FLAGS, 8'h01);
    r16(ADDR_CNT_L, 16'h0001);
    acc(1'b1, ADDR_FLAGS, 8'h01);
    $display("test force and overflow done");
    acc(1'b1, ADDR_CTRL, 8'h10);
    w16(ADDR_CNT_L, 16'h0123);
    cap_pin <= 1'b1;
    repeat (4) @(posedge clk);
    r16(ADDR_CAPT_L, 16'h0123);
    acc(1'b0, ADDR_FLAGS, 8'h20);
    pulse(4'h8);
    acc(1'b1, ADDR_CTRL, 8'h30);
    w16(ADDR_CNT_L, 16'h0456);
    cmp_out <= 1'b1;
    repeat (4) @(posedge clk);
    r16(ADDR_CAPT_L, 16'h0456);
    acc(1'b1, ADDR_FLAGS, 8'h20);
    acc(1'b1, ADDR_CTRL, 8'h0c);
    w16(ADDR_CAPT_L, 16'h0010);
    w16(ADDR_CNT_L, 16'h000e);
    cap_pin <= 1'b0;
    ticks(3);
    r16(ADDR_CNT_L, 16'h0000);
    r16(ADDR_CAPT_L, 16'h0010);
    acc(1'b0, ADDR_FLAGS, 8'h20);
    acc(1'b1, ADDR_MASK, 8'h20);
    repeat (2) @(posedge clk);
    chk(irq_c, 1'b1);
    $display("test capture done");
    for (int k = 0; k < 6; k++) begin
      s = 16'($urandom());
      s[1:0] = 2'(k);
      oe = 8'($urandom());
      t0 <= 2'($urandom());
      t2 <= 2'($urandom());
      acc(1'b1, ADDR_SEL_LOW, s[7:0]);
      acc(1'b1, ADDR_SEL_HIGH, s[15:8]);
      acc(1'b1, ADDR_OE, oe);
      repeat (3) @(posedge clk);
      ocs = {oc_a, oc_b};
      for (int i = 0; i < 8; i++) begin
        e = s[2*i+1] ? t2[i%2] : s[2*i] ? ocs[i%2] : t0[i%2];
        chk(pad[i], oe[i] ? e : 1'b1);
      end
      chk(pin_oe, oe);
      r16(ADDR_SEL_LOW, s);
    end
    $display("test pin mux done");
    end_sim();
  end
endmodule : tb_top
bind tmr16_top tmr16_sva chk_i (.i_ref_clk(i_ref_clk), .i_srst(i_srst),
  .i_io_addr(i_io_addr), .i_io_wr(i_io_wr), .i_io_rd(i_io_rd),
  .i_io_wdata(i_io_wdata), .o_io_rdata(o_io_rdata),
  .i_global_irq_enable(i_global_irq_enable),
  .i_timer0_compare_output(i_timer0_compare_output),
  .i_timer2_compare_output(i_timer2_compare_output),
  .o_capture_irq(o_capture_irq), .o_compare_a_irq(o_compare_a_irq),
  .o_compare_b_irq(o_compare_b_irq), .o_overflow_irq(o_overflow_irq),
  .o_channel_a_compare_output(o_channel_a_compare_output),
  .o_channel_b_compare_output(o_channel_b_compare_output),
  .o_timer_output_pin(o_timer_output_pin),
  .o_timer_output_pin_oe(o_timer_output_pin_oe));
